// File: verilog/cmp_pkg.sv
// Constants and types for the comparator output control block
package cmp_pkg;
  localparam int NUM_CH = 2;
  localparam int PIN_W = 6;
  localparam int ADDR_W = 5;
  // Dedicated result pins of the two channels
  localparam int FIRST_RESULT_PIN = 2;
  localparam int SECOND_RESULT_PIN = 3;
  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL0_CH0 = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_CTRL0_CH1 = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_PIN_LEVEL = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_PIN_DIR = 5'h0c;
  localparam logic [ADDR_W-1:0] OFS_ANALOG_SEL = 5'h10;
  localparam logic [ADDR_W-1:0] OFS_PORT_LATCH = 5'h14;
  localparam logic [ADDR_W-1:0] OFS_SHUTDOWN = 5'h18;
  // Control register 0 field positions
  localparam int CTRL_ENABLE_BIT = 7;
  localparam int CTRL_RESULT_BIT = 6;
  localparam int CTRL_PIN_EN_BIT = 5;
  localparam int CTRL_INVERT_BIT = 4;
  localparam int CTRL_UNUSED_BIT = 3;
  localparam int CTRL_SPEED_BIT = 2;
  localparam int CTRL_HYST_BIT = 1;
  localparam int CTRL_SYNC_BIT = 0;
  localparam logic [7:0] CTRL0_RESET = 8'h04;
  localparam logic [7:0] CTRL0_WMASK = 8'hb7;
  // Shutdown control field positions
  localparam int SHD_SRC0_BIT = 0;
  localparam int SHD_SRC1_BIT = 1;
  localparam int SHD_RESTART_BIT = 2;
  localparam int SHD_STATE_BIT = 3;
  localparam logic [3:0] SHD_RESET = 4'h0;
  // Pins reset to analog inputs
  localparam logic [PIN_W-1:0] PIN_DIR_RESET = 6'h3f;
  localparam logic [PIN_W-1:0] ANALOG_SEL_RESET = 6'h3f;
  localparam logic [PIN_W-1:0] PORT_LATCH_RESET = 6'h00;

  typedef struct packed {
    logic enable;
    logic result;
    logic pin_en;
    logic invert;
    logic unused;
    logic speed;
    logic hyst;
    logic sync;
  } cmp_ctrl0_s;
endpackage

// File: verilog/cmp_sync2.sv
// Two-flop synchroniser for comparator, pin and timer clock levels
`timescale 1ns/1ps
module cmp_sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Levels
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= async_i;
      sync_r <= meta_r;
    end
  end

  assign sync_o = sync_r;
endmodule

// File: verilog/cmp_chan.sv
// One comparator channel: gating, polarity, timer-synchronous latch
`timescale 1ns/1ps
module cmp_chan
  import cmp_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Control and inputs
  input wire cmp_ctrl0_s ctrl_i,
  input wire logic raw_i,
  input wire logic timer_fall_i,
  // Results
  output logic result_o,
  output logic route_o
);
  logic live;
  logic result_r;
  logic hold_r;

  // Disabled comparator reads low before inversion
  assign live = (ctrl_i.enable & raw_i) ^ ctrl_i.invert;

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      result_r <= 1'b0;
    end else begin
      result_r <= live;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      hold_r <= 1'b0;
    end else if (timer_fall_i) begin
      hold_r <= live;
    end
  end

  // Async mode passes the live value through without a clock stage
  assign route_o = ctrl_i.sync ? hold_r : live;
  assign result_o = result_r;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  a_sync_hold: assert property (ctrl_i.sync && !timer_fall_i && $past(ctrl_i.sync) |=> $stable(route_o) || !ctrl_i.sync)
    else $error("synced result moved without timer fall");
  a_invert_map: assert property (ctrl_i.enable && !ctrl_i.sync |-> route_o == (raw_i ^ ctrl_i.invert))
    else $error("result polarity wrong");
  c_sync_latch: cover property (ctrl_i.sync && timer_fall_i ##1 $changed(route_o));
endmodule

// File: verilog/cmp_ctrl.sv
// Comparator pair control registers, pin override and PWM shutdown routing
`timescale 1ns/1ps
module cmp_ctrl
  import cmp_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Avalon-MM slave
  input wire logic [ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Analog front end
  input wire logic [NUM_CH-1:0] cmp_raw_i,
  output logic [NUM_CH-1:0] cmp_enable_o,
  output logic [NUM_CH-1:0] cmp_speed_o,
  output logic [NUM_CH-1:0] cmp_hyst_o,
  // Port pins
  input wire logic [PIN_W-1:0] pin_i,
  output logic [PIN_W-1:0] pin_o,
  output logic [PIN_W-1:0] pin_oe_o,
  // Gate timer
  input wire logic timer_clk_i,
  output logic [NUM_CH-1:0] timer_gate_src_o,
  // PWM shutdown logic
  output logic pwm_shutdown_o
);
  cmp_ctrl0_s ctrl_r [NUM_CH];
  logic [PIN_W-1:0] pin_dir_r;
  logic [PIN_W-1:0] analog_sel_r;
  logic [PIN_W-1:0] port_latch_r;
  logic [NUM_CH-1:0] shd_src_r;
  logic shd_restart_r;
  logic shd_state_r;
  logic shd_state_nxt;
  logic ack_r;
  logic [31:0] readdata_r;
  logic [31:0] rd_nxt;
  logic access;
  logic wr_take;
  logic [NUM_CH-1:0] raw_sync;
  logic [PIN_W-1:0] pin_sync;
  logic tclk_sync;
  logic tclk_prev_r;
  logic timer_fall;
  logic [NUM_CH-1:0] result;
  logic [NUM_CH-1:0] route;
  logic shd_cond;
  logic [PIN_W-1:0] override;

  // Outside levels pass two flops first
  cmp_sync2 #(.W(NUM_CH + PIN_W + 1)) u_sync (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .async_i({cmp_raw_i, pin_i, timer_clk_i}),
    .sync_o({raw_sync, pin_sync, tclk_sync})
  );

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      tclk_prev_r <= 1'b0;
    end else begin
      tclk_prev_r <= tclk_sync;
    end
  end

  // Latch on the falling edge so the timer's rising edge sees a settled gate
  assign timer_fall = tclk_prev_r & ~tclk_sync;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
      cmp_chan u_chan (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .ctrl_i(ctrl_r[gi]),
        .raw_i(raw_sync[gi]),
        .timer_fall_i(timer_fall),
        .result_o(result[gi]),
        .route_o(route[gi])
      );
      assign cmp_enable_o[gi] = ctrl_r[gi].enable;
      assign cmp_speed_o[gi] = ctrl_r[gi].speed;
      assign cmp_hyst_o[gi] = ctrl_r[gi].hyst;
    end
  endgenerate

  assign timer_gate_src_o = route;

  // Avalon slave: one wait state on every access
  assign access = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = access & ~ack_r;
  assign wr_take = avs_write_i & ack_r & avs_byteenable_i[0];

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= access & ~ack_r;
    end
  end

  always_comb begin
    rd_nxt = 32'h0000_0000;
    unique case (avs_address_i)
      OFS_CTRL0_CH0: rd_nxt[7:0] = {ctrl_r[0].enable, result[0], ctrl_r[0][5:4], 1'b0, ctrl_r[0][2:0]};
      OFS_CTRL0_CH1: rd_nxt[7:0] = {ctrl_r[1].enable, result[1], ctrl_r[1][5:4], 1'b0, ctrl_r[1][2:0]};
      OFS_PIN_LEVEL: rd_nxt[PIN_W-1:0] = pin_sync & ~analog_sel_r;
      OFS_PIN_DIR: rd_nxt[PIN_W-1:0] = pin_dir_r;
      OFS_ANALOG_SEL: rd_nxt[PIN_W-1:0] = analog_sel_r;
      OFS_PORT_LATCH: rd_nxt[PIN_W-1:0] = port_latch_r;
      OFS_SHUTDOWN: rd_nxt[3:0] = {shd_state_r, shd_restart_r, shd_src_r};
      default: rd_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      readdata_r <= 32'h0000_0000;
    end else if (avs_read_i && !ack_r) begin
      readdata_r <= rd_nxt;
    end
  end

  assign avs_readdata_o = readdata_r;

  // Control register 0 per channel; result and bit 3 are not storable
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_reg
      localparam logic [ADDR_W-1:0] OFS = (gi == 0) ? OFS_CTRL0_CH0 : OFS_CTRL0_CH1;
      always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
          ctrl_r[gi] <= CTRL0_RESET;
        end else if (wr_take && avs_address_i == OFS) begin
          ctrl_r[gi] <= avs_writedata_i[7:0] & CTRL0_WMASK;
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      pin_dir_r <= PIN_DIR_RESET;
      analog_sel_r <= ANALOG_SEL_RESET;
      port_latch_r <= PORT_LATCH_RESET;
    end else if (wr_take) begin
      if (avs_address_i == OFS_PIN_DIR) begin
        pin_dir_r <= avs_writedata_i[PIN_W-1:0];
      end
      if (avs_address_i == OFS_ANALOG_SEL) begin
        analog_sel_r <= avs_writedata_i[PIN_W-1:0];
      end
      if (avs_address_i == OFS_PORT_LATCH) begin
        port_latch_r <= avs_writedata_i[PIN_W-1:0];
      end
    end
  end

  // Pin override ignores the comparator enable bit
  always_comb begin
    override = '0;
    override[FIRST_RESULT_PIN] = ctrl_r[0].pin_en;
    override[SECOND_RESULT_PIN] = ctrl_r[1].pin_en;
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      pin_o <= PORT_LATCH_RESET;
    end else begin
      pin_o <= port_latch_r;
      if (override[FIRST_RESULT_PIN]) begin
        pin_o[FIRST_RESULT_PIN] <= route[0];
      end
      if (override[SECOND_RESULT_PIN]) begin
        pin_o[SECOND_RESULT_PIN] <= route[1];
      end
    end
  end

  // Driver stays off while the direction bit marks an input
  assign pin_oe_o = ~pin_dir_r;

  // Shutdown: any selected result high trips PWM
  assign shd_cond = |(shd_src_r & route);

  always_comb begin
    shd_state_nxt = shd_state_r;
    if (shd_restart_r && !shd_cond) begin
      shd_state_nxt = 1'b0;
    end
    if (wr_take && avs_address_i == OFS_SHUTDOWN && avs_writedata_i[SHD_STATE_BIT]) begin
      shd_state_nxt = 1'b0;
    end
    // Set wins over a clear in the same cycle
    if (shd_cond) begin
      shd_state_nxt = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      shd_src_r <= SHD_RESET[NUM_CH-1:0];
      shd_restart_r <= SHD_RESET[SHD_RESTART_BIT];
    end else if (wr_take && avs_address_i == OFS_SHUTDOWN) begin
      shd_src_r <= avs_writedata_i[SHD_SRC1_BIT:SHD_SRC0_BIT];
      shd_restart_r <= avs_writedata_i[SHD_RESTART_BIT];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      shd_state_r <= SHD_RESET[SHD_STATE_BIT];
    end else begin
      shd_state_r <= shd_state_nxt;
    end
  end

  // Software should read back the result before arming a source
  assign pwm_shutdown_o = shd_state_r;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  a_pin_override: assert property (ctrl_r[0].pin_en |=> pin_o[FIRST_RESULT_PIN] == $past(route[0]))
    else $error("first result pin not overridden");
  a_pin_latch: assert property (!ctrl_r[1].pin_en |=> pin_o[SECOND_RESULT_PIN] == $past(port_latch_r[SECOND_RESULT_PIN]))
    else $error("second pin not from latch");
  a_dir_gate: assert property (pin_oe_o == ~pin_dir_r)
    else $error("pin enable ignores direction");
  a_analog_zero: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i == OFS_PIN_LEVEL
      |-> (avs_readdata_o[PIN_W-1:0] & analog_sel_r) == '0)
    else $error("analog pin read nonzero");
  a_ctrl_layout: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i == OFS_CTRL0_CH0
      |-> avs_readdata_o[CTRL_UNUSED_BIT] == 1'b0 && avs_readdata_o[CTRL_RESULT_BIT] == $past(result[0]))
    else $error("control readback layout wrong");
  a_hyst_speed: assert property (wr_take && avs_address_i == OFS_CTRL0_CH1
      |=> cmp_hyst_o[1] == $past(avs_writedata_i[CTRL_HYST_BIT]) && cmp_speed_o[1] == $past(avs_writedata_i[CTRL_SPEED_BIT]))
    else $error("hysteresis or speed not written");
  a_shut_set: assert property (shd_cond |=> pwm_shutdown_o)
    else $error("shutdown missed selected result");
  a_shut_restart: assert property (shd_restart_r && !shd_cond |=> !pwm_shutdown_o)
    else $error("auto restart did not release");
  a_one_wait: assert property (access && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("bus answer later than one wait");
  a_speed_reset: assert property ($rose(rst_n_i) |-> cmp_speed_o == '1)
    else $error("speed not normal after reset");

  // Bus side: lane 0 carries every register, the others alone change nothing
  a_lane_guard: assert property (avs_write_i && !avs_byteenable_i[0]
      |=> $stable(pin_dir_r) && $stable(analog_sel_r) && $stable(port_latch_r))
    else $error("write without lane 0 changed a register");
  a_unmapped_read: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i > OFS_SHUTDOWN
      |-> avs_readdata_o == 32'h0000_0000)
    else $error("unmapped address read nonzero");
  a_rdata_hold: assert property (!(avs_read_i && !ack_r) |=> $stable(avs_readdata_o))
    else $error("read data moved outside a read");
  a_ctrl1_layout: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i == OFS_CTRL0_CH1
      |-> avs_readdata_o[CTRL_UNUSED_BIT] == 1'b0 && avs_readdata_o[CTRL_RESULT_BIT] == $past(result[1]))
    else $error("second control readback layout wrong");
  a_result_ro: assert property (wr_take && avs_address_i == OFS_CTRL0_CH1
      |=> ctrl_r[1].result == 1'b0 && ctrl_r[1].unused == 1'b0)
    else $error("read-only control bits stored");
  a_enable_write: assert property (wr_take && avs_address_i == OFS_CTRL0_CH0
      |=> cmp_enable_o[0] == $past(avs_writedata_i[CTRL_ENABLE_BIT]))
    else $error("enable bit not written");
  a_hyst_speed0: assert property (wr_take && avs_address_i == OFS_CTRL0_CH0
      |=> cmp_hyst_o[0] == $past(avs_writedata_i[CTRL_HYST_BIT]) && cmp_speed_o[0] == $past(avs_writedata_i[CTRL_SPEED_BIT]))
    else $error("first hysteresis or speed not written");
  // Digital pins show the synced level loaded with the read
  a_digital_read: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i == OFS_PIN_LEVEL
      |-> avs_readdata_o[PIN_W-1:0] == ($past(pin_sync) & ~$past(analog_sel_r)))
    else $error("digital pin level read wrong");

  // Pin side
  a_pin_override1: assert property (ctrl_r[1].pin_en |=> pin_o[SECOND_RESULT_PIN] == $past(route[1]))
    else $error("second result pin not overridden");
  a_pin_latch0: assert property (!ctrl_r[0].pin_en |=> pin_o[FIRST_RESULT_PIN] == $past(port_latch_r[FIRST_RESULT_PIN]))
    else $error("first pin not from latch");
  a_other_pins: assert property (rst_n_i
      |=> pin_o[1:0] == $past(port_latch_r[1:0]) && pin_o[5:4] == $past(port_latch_r[5:4]))
    else $error("plain pin not from latch");
  a_oe_reset: assert property ($rose(rst_n_i)
      |-> pin_oe_o == '0 && !pwm_shutdown_o && cmp_enable_o == '0 && timer_gate_src_o == '0)
    else $error("outputs not idle after reset");

  // Timer side: only a seen high-then-low level counts as a fall
  a_fall_edge: assert property (timer_fall |-> $past(tclk_sync) && !tclk_sync)
    else $error("timer fall without falling level");
  a_gate_hold1: assert property (ctrl_r[1].sync && !timer_fall |=> $stable(timer_gate_src_o[1]) || !ctrl_r[1].sync)
    else $error("second gate source moved without timer fall");

  // Shutdown state: sticky without restart, never raised without a source
  a_shut_sticky: assert property (pwm_shutdown_o && !shd_restart_r && !wr_take |=> pwm_shutdown_o)
    else $error("shutdown dropped without restart or clear");
  a_shut_clear: assert property (wr_take && avs_address_i == OFS_SHUTDOWN && avs_writedata_i[SHD_STATE_BIT]
      && !shd_cond |=> !pwm_shutdown_o)
    else $error("shutdown clear ignored");
  a_shut_idle: assert property (!pwm_shutdown_o && !shd_cond |=> !pwm_shutdown_o)
    else $error("shutdown raised without a source");

  c_shut_restart: cover property (pwm_shutdown_o ##[1:50] !pwm_shutdown_o);
  c_both_src: cover property (shd_src_r == 2'b11 && shd_cond);
  c_pin_read: cover property (avs_read_i && !avs_waitrequest_o && avs_address_i == OFS_PIN_LEVEL);
  c_sticky_hold: cover property (pwm_shutdown_o && !shd_restart_r ##1 pwm_shutdown_o);
endmodule

// File: sim/cmp_far_model.sv
// Far-side model: gate timer clock source and PWM run state
`timescale 1ns/1ps
module cmp_far_model
  import cmp_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Bench control
  input wire logic tick_i,
  // Block side
  input wire logic shutdown_i,
  output logic timer_clk_o,
  output logic pwm_run_o
);
  logic [2:0] high_cnt_r;
  // One timer clock pulse per tick; rests low between pulses
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      high_cnt_r <= 3'h0;
    end else if (tick_i) begin
      high_cnt_r <= 3'h4;
    end else if (high_cnt_r != 3'h0) begin
      high_cnt_r <= high_cnt_r - 3'h1;
    end
  end
  assign timer_clk_o = (high_cnt_r != 3'h0);
  // PWM resumes one clock after the request drops
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      pwm_run_o <= 1'b0;
    end else begin
      pwm_run_o <= !shutdown_i;
    end
  end
endmodule

// File: sim/comparator_output_control_bench.sv
// Self-checking bench for the comparator output control block
`timescale 1ns/1ps
module comparator_output_control_bench;
  import cmp_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic rd_en = 1'b0;
  logic wr_en = 1'b0;
  logic [3:0] be = 4'hf;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic wait_req;
  logic [NUM_CH-1:0] raw = '0;
  logic [NUM_CH-1:0] en_o, sp_o, hy_o, gsrc;
  logic [PIN_W-1:0] pin_in = '0;
  logic [PIN_W-1:0] pin_out, pin_oe, mask;
  logic tick = 1'b0;
  logic tclk, shd, pwm_run;
  logic [31:0] exp_q[$];
  int fail_count = 0;
  int samples_checked = 0;

  always #2.5 clk = ~clk;

  cmp_ctrl cmp_ctrl_i (.core_clk_i(clk), .rst_n_i(rst_n), .avs_address_i(addr), .avs_read_i(rd_en),
    .avs_write_i(wr_en), .avs_byteenable_i(be), .avs_writedata_i(wdata), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wait_req), .cmp_raw_i(raw), .cmp_enable_o(en_o), .cmp_speed_o(sp_o),
    .cmp_hyst_o(hy_o), .pin_i(pin_in), .pin_o(pin_out), .pin_oe_o(pin_oe), .timer_clk_i(tclk),
    .timer_gate_src_o(gsrc), .pwm_shutdown_o(shd));
  cmp_far_model cmp_far_model_i (.core_clk_i(clk), .rst_n_i(rst_n), .tick_i(tick), .shutdown_i(shd),
    .timer_clk_o(tclk), .pwm_run_o(pwm_run));

  task automatic fail(input string msg);
    fail_count++;
    $display("MISMATCH at %0t: %s", $time, msg);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) fail($sformatf("%s got %h expected %h", what, got, exp));
  endtask
  // Request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr_en <= w;
    rd_en <= !w;
    // No local timeout; only the watchdog ends a stuck wait
    do begin
      @(posedge clk);
    end while (wait_req !== 1'b0);
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] e);
    exp_q.push_back({24'h0, e});
    bus(1'b0, a, 32'h0);
  endtask
  task automatic waitc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic pulse();
    tick <= 1'b1;
    @(posedge clk);
    tick <= 1'b0;
  endtask
  task automatic print_verdict();
    $display("Comparisons: %0d, mismatches: %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Read data checked against the oldest note
  always @(posedge clk) begin
    if (rd_en && wait_req === 1'b0) begin
      if (exp_q.size() == 0) fail("unexpected read data");
      else chk(rdata, exp_q.pop_front(), "read data");
    end
  end

  initial begin
    waitc(5000);
    fail("watchdog expired");
    print_verdict();
  end

  initial begin
    void'($urandom(59));
    @(posedge clk);
    pin_in <= PIN_W'($urandom);
    waitc(11);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(OFS_CTRL0_CH0, CTRL0_RESET);
    rd(OFS_CTRL0_CH1, CTRL0_RESET);
    rd(OFS_PIN_DIR, 8'h3f);
    rd(OFS_ANALOG_SEL, 8'h3f);
    rd(OFS_PORT_LATCH, 8'h00);
    rd(OFS_SHUTDOWN, 8'h00);
    rd(5'h1c, 8'h00);
    rd(OFS_PIN_LEVEL, 8'h00);
    chk(sp_o, 2'b11, "speed reset");
    wr(OFS_CTRL0_CH1, 32'hff);
    waitc(4);
    rd(OFS_CTRL0_CH1, 8'hf7);
    chk({hy_o, en_o}, 4'ha, "hyst and enable");
    wr(OFS_CTRL0_CH1, 32'h00);
    waitc(4);
    rd(OFS_CTRL0_CH1, 8'h00);
    chk({hy_o, sp_o}, 4'h1, "low power, no hyst");
    for (int i = 0; i < 4; i++) begin
      raw <= {1'b0, i[0]};
      wr(OFS_CTRL0_CH0, i[1] ? 32'h94 : 32'h84);
      waitc(6);
      rd(OFS_CTRL0_CH0, {1'b1, i[0] ^ i[1], 1'b0, i[1], 4'h4});
      chk(gsrc[0], i[0] ^ i[1], "routed polarity");
    end
    // Disabled channel 0 still overrides its pin
    raw <= 2'b00;
    wr(OFS_CTRL0_CH0, 32'h34);
    wr(OFS_CTRL0_CH1, 32'ha4);
    // A write without lane 0 leaves the latch alone
    be <= 4'he;
    wr(OFS_PORT_LATCH, 32'h3f);
    be <= 4'hf;
    rd(OFS_PORT_LATCH, 8'h00);
    wr(OFS_PORT_LATCH, 32'h08);
    wr(OFS_PIN_DIR, 32'h33);
    waitc(6);
    chk(pin_oe, 6'h0c, "pin drive");
    chk(pin_out[3:2], 2'b01, "result pins");
    wr(OFS_CTRL0_CH0, 32'h14);
    waitc(4);
    chk(pin_out[2], 1'b0, "latch back on pin");
    wr(OFS_PIN_DIR, 32'h3f);
    waitc(2);
    chk(pin_oe, 6'h00, "pins released");
    wr(OFS_ANALOG_SEL, 32'h0);
    mask = PIN_W'($urandom);
    pin_in <= PIN_W'($urandom);
    waitc(4);
    rd(OFS_PIN_LEVEL, {2'b00, pin_in});
    wr(OFS_ANALOG_SEL, {26'h0, mask});
    rd(OFS_PIN_LEVEL, {2'b00, pin_in & ~mask});
    wr(OFS_CTRL0_CH0, 32'h85);
    pulse();
    waitc(12);
    chk(gsrc[0], 1'b0, "held before fall");
    raw <= 2'b01;
    waitc(12);
    chk(gsrc[0], 1'b0, "no timer fall yet");
    pulse();
    waitc(12);
    chk(gsrc[0], 1'b1, "updated on fall");
    wr(OFS_CTRL0_CH0, 32'h84);
    raw <= 2'b00;
    waitc(4);
    chk(gsrc[0], 1'b0, "async pass");
    wr(OFS_CTRL0_CH1, 32'h84);
    rd(OFS_CTRL0_CH0, 8'h84);
    rd(OFS_CTRL0_CH1, 8'h84);
    for (int k = 2; k < 8; k++) begin
      wr(OFS_SHUTDOWN, {29'h0, k[2], k[1:0] == 2'b00 ? 2'b11 : k[1:0]});
      raw <= k[1:0] == 2'b00 ? 2'b00 : ~k[1:0];
      waitc(6);
      chk(shd, 1'b0, "unselected source");
      raw <= k[1:0] == 2'b00 ? 2'b11 : k[1:0];
      waitc(6);
      chk(shd, 1'b1, "shutdown raised");
      chk(gsrc, k[1:0] == 2'b00 ? 2'b11 : k[1:0], "routed results");
      raw <= 2'b00;
      waitc(6);
      chk({shd, pwm_run}, {!k[2], k[2]}, "restart or sticky");
      wr(OFS_SHUTDOWN, 32'h08);
      waitc(4);
      chk(shd, 1'b0, "state cleared");
    end
    waitc(2);
    print_verdict();
  end
endmodule
